// [verilog/serial_port_pkg.sv]
/*
  constants shared by the four-mode serial port: register addresses,
  control bit positions, mode codes and cycle counts.
  assumes a core clock of 50 MHz and an 8-bit special-register port.
*/
package serial_port_pkg;

  // ---------------------------------------------------------------
  // register addresses and reset value
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_ADDR = 8'h98;
  localparam logic [7:0] DATA_ADDR    = 8'h99;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // control register bit positions
  // ---------------------------------------------------------------
  localparam int BIT_MODE_HIGH = 7;
  localparam int BIT_MODE_LOW  = 6;
  localparam int BIT_MULTIPROC = 5;
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_TX_NINTH  = 3;
  localparam int BIT_RX_NINTH  = 2;
  localparam int BIT_TX_DONE   = 1;
  localparam int BIT_RX_DONE   = 0;

  // ---------------------------------------------------------------
  // mode codes {mode_select_high, mode_select_low}
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_SHIFT   = 2'h0;
  localparam logic [1:0] MODE_UART8   = 2'h1;
  localparam logic [1:0] MODE_UART9_F = 2'h2;
  localparam logic [1:0] MODE_UART9_V = 2'h3;

  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam int OVERSAMPLE     = 16;
  localparam int MODE0_DIV      = 12;
  localparam int MODE2_DIV_SLOW = 64;
  localparam int MODE2_DIV_FAST = 32;
  localparam logic [3:0] MID_START_TICK = 4'h7;
  localparam logic [3:0] LAST_TICK      = 4'hf;
  localparam logic [3:0] BITS_UART8     = 4'h9;
  localparam logic [3:0] BITS_UART9     = 4'ha;

  typedef enum {TX_IDLE, TX_WAIT, TX_RUN} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA} rx_state_t;

endpackage

// [verilog/baud_tick_gen.sv]
/*
  oversample tick generator: one pulse per sixteenth of a bit time.
  assumes timer overflow inputs are one-cycle pulses on clk_sys.
*/
`timescale 1ns/100ps
module baud_tick_gen (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic [1:0] mode,
  input  wire logic       rate_double_bit,
  input  wire logic       timer1_overflow,
  input  wire logic       timer2_overflow,
  input  wire logic       use_timer2,
  output logic            tick16
);

  // ---------------------------------------------------------------
  // fixed rate divider and timer 1 halving
  // ---------------------------------------------------------------
  localparam logic [5:0] SLOW_TICKS = 6'(serial_port_pkg::MODE2_DIV_SLOW / serial_port_pkg::OVERSAMPLE);
  localparam logic [5:0] FAST_TICKS = 6'(serial_port_pkg::MODE2_DIV_FAST / serial_port_pkg::OVERSAMPLE);

  logic [5:0] fixed_count;
  logic       half_toggle;
  wire        fixed_mode = (mode == serial_port_pkg::MODE_UART9_F);
  wire  [5:0] fixed_last = (rate_double_bit ? FAST_TICKS : SLOW_TICKS) - 6'h01;
  wire        fixed_hit  = (fixed_count >= fixed_last);
  wire        t1_pulse   = timer1_overflow & (rate_double_bit | half_toggle);
  wire        var_pulse  = use_timer2 ? timer2_overflow : t1_pulse;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fixed_count <= 6'h00;
      half_toggle <= 1'b0;
      tick16      <= 1'b0;
    end else if (clk_en) begin
      fixed_count <= fixed_hit ? 6'h00 : fixed_count + 6'h01;
      if (timer1_overflow)
        half_toggle <= ~half_toggle;
      tick16 <= fixed_mode ? fixed_hit : var_pulse;
    end
  end

endmodule

// [verilog/four_mode_serial_port.sv]
/*
  four-mode serial port: shift register, 8-bit uart and two 9-bit uarts,
  reached through the control/status and data buffer special registers.
  assumes pins synchronous to clk_sys and timer overflows as one-cycle pulses.
*/
// Summary of operation
// - two mode bits select one of four modes
// - mode 1 multiproc: flag needs valid stop bit
// - modes 2/3 multiproc: ninth bit 0 drops flag
// - receive only while receive enable is set
// - transmit ninth-bit field sent as ninth bit
// - ninth-bit field captures ninth or stop bit
// - transmit flag set at bit eight or stop
// - receive flag set bit eight or mid-stop
// - mode 0: data on rx pin, clock on tx
// - mode 0 receive starts: enable set, flag clear
// - mode 1 frame: start, eight data, stop
// - any data buffer write starts transmission
// - mode 1 write loads stop bit ninth position
// - falling edge starts frame, start bit skipped
// - final shift loads buffer only when accepted
// - modes 2/3 frame: start, eight, ninth, stop
// - mode 2 rate core/64 or core/32
// - mode 2 loads data, ninth bit, starts at next bit boundary
// - mode 3 is mode 2 with variable rate
// - modes 1/3 rate from timer overflows
// - mode 0 divisor is a parameter
// - receive shift register separate from buffer
// - data write loads transmit, read returns receive
`timescale 1ns/100ps
module four_mode_serial_port #(
  parameter int MODE0_DIV = serial_port_pkg::MODE0_DIV
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       rate_double_bit,
  input  wire logic       timer1_overflow,
  input  wire logic       timer2_overflow,
  input  wire logic       rx_clk_timer2,
  input  wire logic       tx_clk_timer2,
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe,
  output logic            txd_out
);

  // ---------------------------------------------------------------
  // control/status bits and decode
  // ---------------------------------------------------------------
  logic mode_select_high;
  logic mode_select_low;
  logic multiproc_enable;
  logic rx_enable;
  logic tx_ninth_bit;
  logic rx_ninth_bit;
  logic tx_done_flag;
  logic rx_done_flag;
  logic [7:0] rx_buffer;

  wire [1:0] mode       = {mode_select_high, mode_select_low};
  wire       mode_shift = (mode == serial_port_pkg::MODE_SHIFT);
  wire       mode_uart8 = (mode == serial_port_pkg::MODE_UART8);
  wire [7:0] control_value = {mode_select_high, mode_select_low, multiproc_enable, rx_enable,
                              tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
  wire       wr_control = sfr_wr & (sfr_addr == serial_port_pkg::CONTROL_ADDR);
  wire       wr_data    = sfr_wr & (sfr_addr == serial_port_pkg::DATA_ADDR);

  // ---------------------------------------------------------------
  // baud ticks for each direction
  // ---------------------------------------------------------------
  logic tx_tick;
  logic rx_tick;

  baud_tick_gen tx_ticks (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .clk_en          (clk_en),
    .mode            (mode),
    .rate_double_bit (rate_double_bit),
    .timer1_overflow (timer1_overflow),
    .timer2_overflow (timer2_overflow),
    .use_timer2      (tx_clk_timer2),
    .tick16          (tx_tick)
  );

  baud_tick_gen rx_ticks (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .clk_en          (clk_en),
    .mode            (mode),
    .rate_double_bit (rate_double_bit),
    .timer1_overflow (timer1_overflow),
    .timer2_overflow (timer2_overflow),
    .use_timer2      (rx_clk_timer2),
    .tick16          (rx_tick)
  );

  // ---------------------------------------------------------------
  // mode 0 shift engine
  // ---------------------------------------------------------------
  localparam logic [7:0] M0_LAST = 8'(MODE0_DIV - 1);
  localparam logic [7:0] M0_HALF = 8'(MODE0_DIV / 2);

  logic       m0_busy;
  logic       m0_rx;
  logic [7:0] m0_phase;
  logic [2:0] m0_bit;
  logic [7:0] m0_shift;

  wire m0_rx_start = mode_shift & rx_enable & ~rx_done_flag & ~m0_busy & ~wr_data;
  wire m0_bit_end  = m0_busy & (m0_phase == M0_LAST);
  wire m0_done     = m0_bit_end & (m0_bit == 3'h7);
  wire m0_tx_done  = m0_done & ~m0_rx;
  wire m0_rx_done  = m0_done & m0_rx;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      m0_busy  <= 1'b0;
      m0_rx    <= 1'b0;
      m0_phase <= 8'h00;
      m0_bit   <= 3'h0;
      m0_shift <= 8'h00;
    end else if (clk_en) begin
      if (mode_shift & wr_data) begin
        m0_busy  <= 1'b1;
        m0_rx    <= 1'b0;
        m0_phase <= 8'h00;
        m0_bit   <= 3'h0;
        m0_shift <= sfr_wdata;
      end else if (m0_rx_start) begin
        m0_busy  <= 1'b1;
        m0_rx    <= 1'b1;
        m0_phase <= 8'h00;
        m0_bit   <= 3'h0;
      end else if (m0_busy) begin
        m0_phase <= m0_bit_end ? 8'h00 : m0_phase + 8'h01;
        if (m0_rx & (m0_phase == M0_HALF))
          m0_shift <= {rxd_in, m0_shift[7:1]};
        if (m0_bit_end) begin
          m0_bit <= m0_bit + 3'h1;
          if (!m0_rx)
            m0_shift <= {1'b1, m0_shift[7:1]};
          if (m0_done)
            m0_busy <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // asynchronous transmitter
  // ---------------------------------------------------------------
  serial_port_pkg::tx_state_t tx_state;
  logic [3:0] tx_div;
  logic [3:0] tx_left;
  logic [9:0] tx_shift;
  logic       async_txd;

  wire tx_boundary = tx_tick & (tx_div == serial_port_pkg::LAST_TICK);
  wire tx_stop_out = (tx_state == serial_port_pkg::TX_RUN) & tx_boundary & (tx_left == 4'h1);
  wire async_tx_done = tx_stop_out;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tx_state  <= serial_port_pkg::TX_IDLE;
      tx_div    <= 4'h0;
      tx_left   <= 4'h0;
      tx_shift  <= 10'h3ff;
      async_txd <= 1'b1;
    end else if (clk_en) begin
      if (tx_tick)
        tx_div <= tx_div + 4'h1;
      if (!mode_shift & wr_data) begin
        tx_state <= serial_port_pkg::TX_WAIT;
        if (mode_uart8) begin
          tx_shift <= {1'b1, 1'b1, sfr_wdata};
          tx_left  <= serial_port_pkg::BITS_UART8;
        end else begin
          tx_shift <= {1'b1, tx_ninth_bit, sfr_wdata};
          tx_left  <= serial_port_pkg::BITS_UART9;
        end
      end else begin
        case (tx_state)
          serial_port_pkg::TX_IDLE: begin
            async_txd <= 1'b1;
          end
          serial_port_pkg::TX_WAIT: begin
            if (tx_boundary) begin
              async_txd <= 1'b0;
              tx_state  <= serial_port_pkg::TX_RUN;
            end
          end
          serial_port_pkg::TX_RUN: begin
            if (tx_boundary) begin
              if (tx_left == 4'h0) begin
                tx_state  <= serial_port_pkg::TX_IDLE;
                async_txd <= 1'b1;
              end else begin
                async_txd <= tx_shift[0];
                tx_shift  <= {1'b1, tx_shift[9:1]};
                tx_left   <= tx_left - 4'h1;
              end
            end
          end
          default: tx_state <= serial_port_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // asynchronous receiver
  // ---------------------------------------------------------------
  serial_port_pkg::rx_state_t rx_state;
  logic [3:0] rx_div;
  logic [3:0] rx_idx;
  logic [9:0] rx_shift;
  logic       rx_line_prev;

  wire [3:0] rx_last_idx = (mode_uart8 ? serial_port_pkg::BITS_UART8 : serial_port_pkg::BITS_UART9) - 4'h1;
  wire rx_edge   = rx_tick & rx_enable & ~mode_shift & rx_line_prev & ~rxd_in;
  wire rx_sample = (rx_state == serial_port_pkg::RX_DATA) & rx_tick & (rx_div == serial_port_pkg::LAST_TICK);
  wire rx_final  = rx_sample & (rx_idx == rx_last_idx);
  wire rx_ninth  = mode_uart8 ? rxd_in : rx_shift[8];
  wire rx_accept = rx_final & ~rx_done_flag & (~multiproc_enable | rx_ninth);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rx_state     <= serial_port_pkg::RX_IDLE;
      rx_div       <= 4'h0;
      rx_idx       <= 4'h0;
      rx_shift     <= 10'h000;
      rx_line_prev <= 1'b1;
    end else if (clk_en) begin
      if (rx_tick)
        rx_line_prev <= rxd_in;
      case (rx_state)
        serial_port_pkg::RX_IDLE: begin
          if (rx_edge) begin
            rx_state <= serial_port_pkg::RX_START;
            rx_div   <= 4'h0;
          end
        end
        serial_port_pkg::RX_START: begin
          if (rx_tick) begin
            rx_div <= rx_div + 4'h1;
            if (rx_div == serial_port_pkg::MID_START_TICK) begin
              rx_div   <= 4'h0;
              rx_idx   <= 4'h0;
              rx_state <= rxd_in ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
            end
          end
        end
        serial_port_pkg::RX_DATA: begin
          if (rx_tick)
            rx_div <= rx_div + 4'h1;
          if (rx_sample) begin
            rx_shift[rx_idx] <= rxd_in;
            rx_idx <= rx_idx + 4'h1;
            if (rx_final)
              rx_state <= serial_port_pkg::RX_IDLE;
          end
        end
        default: rx_state <= serial_port_pkg::RX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register file: hardware sets win over software clears
  // ---------------------------------------------------------------
  wire set_tx_done = m0_tx_done | async_tx_done;
  wire set_rx_done = m0_rx_done | rx_accept;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      {mode_select_high, mode_select_low, multiproc_enable, rx_enable,
       tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag} <= serial_port_pkg::CONTROL_RESET;
      rx_buffer <= 8'h00;
      sfr_rdata <= 8'h00;
    end else if (clk_en) begin
      if (wr_control) begin
        mode_select_high <= sfr_wdata[serial_port_pkg::BIT_MODE_HIGH];
        mode_select_low  <= sfr_wdata[serial_port_pkg::BIT_MODE_LOW];
        multiproc_enable <= sfr_wdata[serial_port_pkg::BIT_MULTIPROC];
        rx_enable        <= sfr_wdata[serial_port_pkg::BIT_RX_ENABLE];
        tx_ninth_bit     <= sfr_wdata[serial_port_pkg::BIT_TX_NINTH];
        rx_ninth_bit     <= sfr_wdata[serial_port_pkg::BIT_RX_NINTH];
      end
      tx_done_flag <= set_tx_done | (wr_control ? sfr_wdata[serial_port_pkg::BIT_TX_DONE] : tx_done_flag);
      rx_done_flag <= set_rx_done | (wr_control ? sfr_wdata[serial_port_pkg::BIT_RX_DONE] : rx_done_flag);
      if (rx_accept) begin
        rx_buffer    <= rx_shift[7:0];
        rx_ninth_bit <= rx_ninth;
      end else if (m0_rx_done) begin
        rx_buffer <= m0_shift;
      end
      if (sfr_rd)
        sfr_rdata <= (sfr_addr == serial_port_pkg::CONTROL_ADDR) ? control_value :
                     (sfr_addr == serial_port_pkg::DATA_ADDR) ? rx_buffer : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else if (clk_en) begin
      txd_out <= m0_busy ? (m0_phase >= M0_HALF) : async_txd;
      rxd_out <= (m0_busy & ~m0_rx) ? m0_shift[0] : 1'b1;
      rxd_oe  <= m0_busy & ~m0_rx;
    end
  end

endmodule

// [testbench/four_mode_serial_port_monitor.sv]
/*
  checker for four_mode_serial_port, bound to its ports.
  assumes clk_en high and no frame restarted by a write while it runs.
*/
`timescale 1ns/100ps
module four_mode_serial_port_monitor #(
  parameter int MODE0_DIV = 12
) (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       rate_double_bit,
  input wire logic       rxd_oe,
  input wire logic       txd_out
);
  localparam int OE_MIN = 8 * MODE0_DIV - 2;
  localparam int OE_MAX = 8 * MODE0_DIV + 2;
  logic [1:0]  mode_q;
  logic        txd_q;
  logic [15:0] run_cnt;
  logic [15:0] oe_cnt;
  wire         data_wr = clk_en && sfr_wr && (sfr_addr == serial_port_pkg::DATA_ADDR);
  wire         ctl_wr  = clk_en && sfr_wr && (sfr_addr == serial_port_pkg::CONTROL_ADDR);
  wire         odd_rd  = clk_en && sfr_rd && (sfr_addr != serial_port_pkg::DATA_ADDR)
                         && (sfr_addr != serial_port_pkg::CONTROL_ADDR);
  // ---------------------------------------------------------------
  // run length of txd levels, drive time, mode written
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    txd_q   <= txd_out;
    run_cnt <= (txd_out != txd_q) ? 16'h0001 : run_cnt + 16'h0001;
    oe_cnt  <= rxd_oe ? oe_cnt + 16'h0001 : 16'h0000;
    mode_q  <= !reset_n ? 2'h0 : (ctl_wr ? sfr_wdata[7:6] : mode_q);
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_reset_idle;
    disable iff (1'b0) !reset_n |=> txd_out && !rxd_oe && (sfr_rdata == 8'h00);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle in reset");
  property p_odd_read;
    odd_rd |=> sfr_rdata == 8'h00;
  endproperty
  a_odd_read: assert property (p_odd_read) else $error("unmapped read not zero");
  property p_rdata_hold;
    !(clk_en && sfr_rd) |=> $stable(sfr_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
  property p_oe_mode0;
    $rose(rxd_oe) |-> mode_q == serial_port_pkg::MODE_SHIFT;
  endproperty
  a_oe_mode0: assert property (p_oe_mode0) else $error("rxd driven outside mode 0");
  property p_oe_len;
    $fell(rxd_oe) |-> (oe_cnt >= OE_MIN) && (oe_cnt <= OE_MAX);
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("mode 0 transfer length wrong");
  property p_m0_half;
    $rose(txd_out) && (mode_q == serial_port_pkg::MODE_SHIFT) |-> run_cnt == MODE0_DIV / 2;
  endproperty
  a_m0_half: assert property (p_m0_half) else $error("shift clock low phase wrong");
  property p_m0_start;
    data_wr && (mode_q == serial_port_pkg::MODE_SHIFT) |-> ##[1:3] rxd_oe;
  endproperty
  a_m0_start: assert property (p_m0_start) else $error("mode 0 write did not start");
  property p_m2_start;
    data_wr && (mode_q == serial_port_pkg::MODE_UART9_F) |-> ##[1:70] !txd_out;
  endproperty
  a_m2_start: assert property (p_m2_start) else $error("mode 2 start bit late");
  property p_m2_bits;
    $rose(txd_out) && (mode_q == serial_port_pkg::MODE_UART9_F)
      |-> (run_cnt % (rate_double_bit ? 32 : 64)) == 0;
  endproperty
  a_m2_bits: assert property (p_m2_bits) else $error("mode 2 bit time wrong");
endmodule

bind four_mode_serial_port four_mode_serial_port_monitor #(.MODE0_DIV(MODE0_DIV)) four_mode_serial_port_monitor_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rate_double_bit(rate_double_bit),
  .rxd_oe(rxd_oe), .txd_out(txd_out));

// [testbench/serial_partner_model.sv]
/*
  far-side serial device: frame sender, frame receiver, mode 0 shift source.
  assumes the bench resolves the rxd pin from rxd_oe; line idles high.
*/
`timescale 1ns/100ps
module serial_partner_model (
  input  wire logic clk_sys,
  input  wire logic txd_out,
  input  wire logic rxd_oe,
  output logic      line_out
);
  logic [7:0] shift_q;
  logic       shift_on;
  initial begin
    line_out = 1'b1;
    shift_on = 1'b0;
    shift_q  = 8'h00;
  end
  // mode 0: next bit shown on each falling shift clock
  always @(negedge txd_out) begin
    if (shift_on && !rxd_oe) begin
      line_out = shift_q[0];
      shift_q  = {1'b1, shift_q[7:1]};
    end
  end
  task automatic arm_shift(input logic on, input logic [7:0] d);
    shift_on = on;
    shift_q  = d;
    line_out = 1'b1;
  endtask
  // start low, data lsb first, ninth, stop high
  task automatic send_frame(input logic [10:0] bits, input int nbits, input int bclk);
    for (int i = 0; i < nbits; i++) begin
      line_out = bits[i];
      repeat (bclk) @(posedge clk_sys);
      #1;
    end
    line_out = 1'b1;
  endtask
  task automatic recv_frame(output logic [10:0] bits, input int nbits, input int bclk);
    bits = 11'h7ff;
    @(negedge txd_out);
    repeat (bclk / 2) @(posedge clk_sys);
    for (int i = 0; i < nbits; i++) begin
      bits[i] = txd_out;
      repeat (bclk) @(posedge clk_sys);
    end
  endtask
endmodule

// [testbench/four_mode_serial_port_tb.sv]
/*
  bench for the four-mode serial port, one task per scenario.
  assumes the partner model on the pins and overflows every second clock.
*/
`timescale 1ns/100ps
module four_mode_serial_port_tb;
  logic        clk_sys;
  logic        reset_n;
  logic        clk_en;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        rdbl;
  logic        ovf;
  logic        t2sel;
  logic        rxd_out;
  logic        rxd_oe;
  logic        txd_out;
  logic        line_out;
  logic [7:0]  rd_v;
  logic [10:0] fr;
  int          bad_count;
  int          num_checks;
  wire         rxd_pin = rxd_oe ? rxd_out : line_out;

  four_mode_serial_port #(.MODE0_DIV(4)) four_mode_serial_port_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .rate_double_bit(rdbl),
    .timer1_overflow(ovf), .timer2_overflow(ovf), .rx_clk_timer2(t2sel), .tx_clk_timer2(t2sel),
    .rxd_in(rxd_pin), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
  serial_partner_model serial_partner_model_i (
    .clk_sys(clk_sys), .txd_out(txd_out), .rxd_oe(rxd_oe), .line_out(line_out));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) #1 ovf = !ovf && reset_n;
  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
  // ---------------------------------------------------------------
  // bus and comparison tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_rd = 1'b0;
    rd_v   = sfr_rdata;
  endtask
  task automatic wait_ctl(input logic [7:0] m);
    int n;
    n = 0;
    rd(serial_port_pkg::CONTROL_ADDR);
    while ((rd_v & m) !== m && n < 3000) begin
      rd(serial_port_pkg::CONTROL_ADDR);
      n++;
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(serial_port_pkg::CONTROL_ADDR);
    check(rd_v, serial_port_pkg::CONTROL_RESET);
    wr(8'h42, 8'hff);
    rd(8'h42);
    check(rd_v, 8'h00);
    clk_en = 1'b0;
    wr(serial_port_pkg::CONTROL_ADDR, 8'h40);
    clk_en = 1'b1;
    rd(serial_port_pkg::CONTROL_ADDR);
    check(rd_v, serial_port_pkg::CONTROL_RESET);
    $display("test reset end");
  endtask
  task automatic t_m0_tx();
    logic [7:0] got;
    fork
      wr(serial_port_pkg::DATA_ADDR, 8'h6b);
      for (int i = 0; i < 8; i++) begin
        @(posedge txd_out);
        got[i] = rxd_out;
      end
    join
    check(got, 8'h6b);
    wait_ctl(8'h02);
    check(rd_v[1], 1'b1);
    wr(serial_port_pkg::CONTROL_ADDR, 8'h00);
    $display("test m0_tx end");
  endtask
  task automatic t_m0_rx();
    serial_partner_model_i.arm_shift(1'b1, 8'hd2);
    wr(serial_port_pkg::CONTROL_ADDR, 8'h10);
    wait_ctl(8'h01);
    check(rd_v[0], 1'b1);
    rd(serial_port_pkg::DATA_ADDR);
    check(rd_v, 8'hd2);
    serial_partner_model_i.arm_shift(1'b0, 8'h00);
    wr(serial_port_pkg::CONTROL_ADDR, 8'h00);
    $display("test m0_rx end");
  endtask
  task automatic t_tx(input logic [7:0] ctl, input logic [7:0] d, input logic rd2, input logic t2,
                      input int nb, input int bclk);
    rdbl  = rd2;
    t2sel = t2;
    wr(serial_port_pkg::CONTROL_ADDR, ctl);
    fork
      wr(serial_port_pkg::DATA_ADDR, d);
      serial_partner_model_i.recv_frame(fr, nb, bclk);
    join
    check(fr, {1'b1, ctl[3] | (nb == 10), d, 1'b0});
    wait_ctl(8'h02);
    check(rd_v[1], 1'b1);
    wr(serial_port_pkg::CONTROL_ADDR, ctl);
    $display("test tx end");
  endtask
  task automatic t_rx(input logic [7:0] ctl, input logic [7:0] d, input logic b9, input logic t2,
                      input int nb, input logic exp);
    rdbl  = 1'b1;
    t2sel = t2;
    wr(serial_port_pkg::CONTROL_ADDR, ctl);
    serial_partner_model_i.send_frame({1'b1, b9, d, 1'b0}, nb, 32);
    rd(serial_port_pkg::CONTROL_ADDR);
    check(rd_v[0], exp);
    if (exp) begin
      check(rd_v[2], b9);
      rd(serial_port_pkg::DATA_ADDR);
      check(rd_v, d);
    end
    wr(serial_port_pkg::CONTROL_ADDR, 8'h00);
    $display("test rx end");
  endtask
  task automatic t_ovr();
    rdbl  = 1'b1;
    t2sel = 1'b0;
    wr(serial_port_pkg::CONTROL_ADDR, 8'h50);
    serial_partner_model_i.send_frame({2'h3, 8'h41, 1'b0}, 10, 32);
    serial_partner_model_i.send_frame({2'h3, 8'h42, 1'b0}, 10, 32);
    wr(serial_port_pkg::DATA_ADDR, 8'hee);
    rd(serial_port_pkg::DATA_ADDR);
    check(rd_v, 8'h41);
    wait_ctl(8'h02);
    check(rd_v[1], 1'b1);
    wr(serial_port_pkg::CONTROL_ADDR, 8'h00);
    $display("test overrun end");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    bad_count  = 0;
    num_checks = 0;
    reset_n    = 1'b0;
    clk_en     = 1'b1;
    sfr_addr   = 8'h00;
    sfr_wr     = 1'b0;
    sfr_rd     = 1'b0;
    sfr_wdata  = 8'h00;
    rdbl       = 1'b0;
    t2sel      = 1'b0;
    ovf        = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    t_reset();
    t_m0_tx();
    t_m0_rx();
    t_tx(8'h88, 8'ha5, 1'b1, 1'b0, 11, 32);
    t_tx(8'h80, 8'h3c, 1'b0, 1'b0, 11, 64);
    t_tx(8'h40, 8'h96, 1'b1, 1'b0, 10, 32);
    t_tx(8'hc8, 8'h5a, 1'b0, 1'b1, 11, 32);
    t_rx(8'h50, 8'hc3, 1'b1, 1'b0, 10, 1'b1);
    t_rx(8'h70, 8'h11, 1'b0, 1'b0, 10, 1'b0);
    t_rx(8'h50, 8'h22, 1'b0, 1'b0, 10, 1'b1);
    t_rx(8'hf0, 8'h77, 1'b0, 1'b1, 11, 1'b0);
    t_rx(8'hf0, 8'h78, 1'b1, 1'b1, 11, 1'b1);
    t_rx(8'h80, 8'h33, 1'b1, 1'b0, 11, 1'b0);
    t_rx(8'h90, 8'h34, 1'b0, 1'b0, 11, 1'b1);
    t_ovr();
    report_and_stop();
  end
endmodule
